// ---- rtl/vbs_code_match.sv ----
`timescale 1ns/1ps
module vbs_code_match
    import vbs_pkg::*;
(
    input wire logic [15:0] shift_word, // Recent sliced bits
    input wire logic [15:0] codes, // First and second code
    input wire logic [15:0] third_code, // Third code
    input wire logic [15:0] third_mask, // Third code mask
    input wire logic [1:0] sel, // Code select
    output logic hit // Selected code seen
);
    always_comb begin
        unique case (sel)
            CODE_SEL_FIRST: begin
                hit = shift_word[7:0] == codes[FIRST_CODE_LSB +: 8];
            end
            CODE_SEL_SECOND: begin
                hit = shift_word[7:0] == codes[SECOND_CODE_LSB +: 8];
            end
            CODE_SEL_THIRD: begin
                hit = ((shift_word ^ third_code) & third_mask) == ZERO_WORD;
            end
            CODE_SEL_NONE: begin
                hit = 1'b1;
            end
        endcase
    end
endmodule : vbs_code_match

// ---- rtl/vbs_line_if.sv ----
`timescale 1ns/1ps
interface vbs_line_if;
    logic line_start;
    logic line_end;
    logic phase_dev;
    logic [5:0] count;
    modport counter (input line_start, line_end, phase_dev, output count);
    modport user (output line_start, line_end, phase_dev, input count);
endinterface : vbs_line_if

// ---- rtl/vbs_phase_counter.sv ----
`timescale 1ns/1ps
module vbs_phase_counter
    import vbs_pkg::*;
(
    input wire logic clk, // Clock
    input wire logic rst, // Async reset
    vbs_line_if.counter lif // Line events
);
    logic [5:0] cnt;
    logic [5:0] next_cnt;

    always_comb begin
        next_cnt = cnt;
        if (lif.line_start) begin
            next_cnt = 6'h00;
        end else if (lif.phase_dev && cnt != PHASE_COUNT_MAX) begin
            next_cnt = cnt + 6'h01;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt <= 6'h00;
        end else begin
            cnt <= next_cnt;
        end
    end

    assign lif.count = cnt;
endmodule : vbs_phase_counter

// ---- rtl/vbs_pkg.sv ----
package vbs_pkg;
    // Register indices on the plain register port
    localparam logic [3:0] ADDR_RATE = 4'h0;
    localparam logic [3:0] ADDR_ENABLES = 4'h1;
    localparam logic [3:0] ADDR_LINE_CFG = 4'h2;
    localparam logic [3:0] ADDR_COMP_CFG = 4'h3;
    localparam logic [3:0] ADDR_MEASURE = 4'h4;
    localparam logic [3:0] ADDR_BLACK_PHASE = 4'h5;
    localparam logic [3:0] ADDR_CODES = 4'h6;
    localparam logic [3:0] ADDR_THIRD_CODE = 4'h7;
    localparam logic [3:0] ADDR_THIRD_MASK = 4'h8;
    // Compensation config fields
    localparam int SET_LEVEL_LSB = 0;
    localparam int LEVEL_SOURCE_BIT = 7;
    localparam int GDC_LSB = 8;
    localparam int GDEN_BIT = 12;
    // Line config fields
    localparam int RECORDER_BIT = 1;
    localparam int CODE_SEL_LSB = 2;
    // Code field positions in the code register
    localparam int FIRST_CODE_LSB = 0;
    localparam int SECOND_CODE_LSB = 8;
    // Measure status fields
    localparam int CODE_FOUND_BIT = 0;
    localparam int TEST_LINE_BIT = 1;
    localparam int PRELIM_LSB = 2;
    localparam int MEAS_LEVEL_LSB = 8;
    localparam int ATTN_BIT = 15;
    // Black and phase status fields
    localparam int EXACT_LSB = 0;
    localparam int BLACK_LSB = 6;
    // Frame code selections
    localparam logic [1:0] CODE_SEL_FIRST = 2'h0;
    localparam logic [1:0] CODE_SEL_SECOND = 2'h1;
    localparam logic [1:0] CODE_SEL_THIRD = 2'h2;
    localparam logic [1:0] CODE_SEL_NONE = 2'h3;
    // Phase-test decision threshold
    localparam logic [5:0] PHASE_TEST_LIMIT = 6'h1F;
    // Phase counter saturates here
    localparam logic [5:0] PHASE_COUNT_MAX = 6'h3F;
    // Bit count of the last bit of a sliced byte
    localparam logic [2:0] BYTE_LAST_BIT = 3'h7;
    localparam logic [15:0] ZERO_WORD = 16'h0000;
endpackage : vbs_pkg

// ---- rtl/vbs_slicer.sv ----
// Our own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
// Notes on behaviour
// - Select code 11 skips code check; all line data goes to buffer.
// - Recorder bit 0 freezes data PLL after run-in, slow line PLL.
// - Group delay strength acts only while its enable is 1.
// - Level source 0 uses internal level, 1 uses software level.
// - External slicing uses set level; measured output stays internal.
// - Measured slicing level of current line is reported in seven bits.
// - Attenuation flag set when high-band attenuation seen for current line.
// - Six-bit preliminary phase count; above 31 marks a phase-test line.
// - Exact phase count given at end of each line, same decision.
// - Test line flag set when data likely from insertion test line.
// - Code found flag set when code seen and data written.
// - Black level reported as seven bits beside the exact phase count.
// - Parameter words are not reset; software initialises them.
// - Reserved status bits read as zero; parameter words read back as written; software writes zero.
// - Code select 00, 01, 10 pick first, second, third code.
// - Line parameters act on the first slicer only.
module vbs_slicer
    import vbs_pkg::*;
(
    input wire logic CLK, // 200 MHz clock
    input wire logic RST, // Async reset, high
    input wire logic [3:0] ADDR, // Register index
    input wire logic [15:0] WDATA, // Write data
    input wire logic WR, // Write strobe
    input wire logic RD, // Read strobe
    output logic [15:0] RDATA, // Read data, cycle after RD
    input wire logic LINE_START, // First slicer line begins
    input wire logic LINE_END, // First slicer line ends
    input wire logic RUN_IN_DONE, // Clock run-in finished
    input wire logic DATA_BIT, // Sliced data bit
    input wire logic BIT_VALID, // Data bit strobe
    input wire logic PHASE_DEV, // Strong phase deviation seen
    input wire logic [6:0] CALC_LEVEL, // Internal slicing level
    input wire logic [6:0] BLACK_LEVEL, // Measured black level
    input wire logic ATTEN_DETECT, // High-band attenuation seen
    input wire logic INSERT_TEST, // Insertion test line seen
    output logic [6:0] SLICE_LEVEL, // Threshold in use
    output logic [3:0] GD_STRENGTH, // Effective delay compensation
    output logic DPLL_TUNE, // Data PLL tuning enable
    output logic HPLL_FAST, // Line PLL fast time constant
    output logic DATA_WR, // Write sliced byte to buffer
    output logic [7:0] DATA_BYTE, // Sliced byte
    output logic STATUS_WR, // Write line status words
    output logic [15:0] STATUS_MEAS, // Measure status word
    output logic [15:0] STATUS_BLACK // Black and phase word
);
    ////////////////////////////////////////////////////////////////////////
    // Parameter words, not reset
    logic [15:0] rate_word;
    logic [15:0] enable_word;
    logic [15:0] line_cfg;
    logic [15:0] comp_cfg;
    logic [15:0] codes_word;
    logic [15:0] third_code;
    logic [15:0] third_mask;

    always_ff @(posedge CLK) begin
        if (WR) begin
            unique case (ADDR)
                ADDR_RATE: rate_word <= WDATA;
                ADDR_ENABLES: enable_word <= WDATA;
                ADDR_LINE_CFG: line_cfg <= WDATA;
                ADDR_COMP_CFG: comp_cfg <= WDATA;
                ADDR_CODES: codes_word <= WDATA;
                ADDR_THIRD_CODE: third_code <= WDATA;
                ADDR_THIRD_MASK: third_mask <= WDATA;
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Line status state
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_LINE = 2'b10
    } vbs_state_t;
    vbs_state_t state;
    vbs_state_t next_state;
    logic [15:0] shift;
    logic [15:0] next_shift;
    logic [2:0] bit_cnt;
    logic [2:0] next_bit_cnt;
    logic code_seen;
    logic next_code_seen;
    logic run_in;
    logic next_run_in;
    logic [15:0] meas;
    logic [15:0] next_meas;
    logic [15:0] black;
    logic [15:0] next_black;
    logic hit;
    logic [1:0] code_sel;
    logic [15:0] shift_in;
    logic recorder;
    logic data_wr_c;
    logic [7:0] data_byte_c;
    logic status_wr_c;
    logic [5:0] prelim;
    logic test_flag;

    vbs_line_if lif ();
    assign lif.line_start = LINE_START;
    assign lif.line_end = LINE_END;
    assign lif.phase_dev = PHASE_DEV;
    assign prelim = lif.count;

    vbs_phase_counter u_cnt (
        .clk(CLK),
        .rst(RST),
        .lif(lif)
    );

    assign code_sel = line_cfg[CODE_SEL_LSB +: 2];
    assign recorder = line_cfg[RECORDER_BIT];
    // Match on the window that includes the bit arriving now
    assign shift_in = {shift[14:0], DATA_BIT};

    vbs_code_match u_match (
        .shift_word(shift_in),
        .codes(codes_word),
        .third_code(third_code),
        .third_mask(third_mask),
        .sel(code_sel),
        .hit(hit)
    );

    assign test_flag = INSERT_TEST || (prelim > PHASE_TEST_LIMIT);

    always_comb begin
        next_state = state;
        next_shift = shift;
        next_bit_cnt = bit_cnt;
        next_code_seen = code_seen;
        next_run_in = run_in;
        next_meas = meas;
        next_black = black;
        data_wr_c = 1'b0;
        data_byte_c = shift[7:0];
        status_wr_c = 1'b0;
        unique case (state)
            ST_IDLE: begin
                if (LINE_START) begin
                    next_state = ST_LINE;
                    next_code_seen = code_sel == CODE_SEL_NONE;
                    next_run_in = 1'b0;
                    next_bit_cnt = 3'h0;
                    next_shift = ZERO_WORD;
                end
            end
            ST_LINE: begin
                if (RUN_IN_DONE) begin
                    next_run_in = 1'b1;
                end
                if (BIT_VALID) begin
                    next_shift = shift_in;
                    next_bit_cnt = bit_cnt + 3'h1;
                    if (code_seen && bit_cnt == BYTE_LAST_BIT) begin
                        data_wr_c = 1'b1;
                        data_byte_c = {shift[6:0], DATA_BIT};
                    end
                    if (!code_seen && hit) begin
                        next_code_seen = 1'b1;
                        next_bit_cnt = 3'h0;
                    end
                end
                if (LINE_END) begin
                    next_state = ST_IDLE;
                    status_wr_c = 1'b1;
                    next_meas = ZERO_WORD;
                    next_meas[ATTN_BIT] = ATTEN_DETECT;
                    next_meas[MEAS_LEVEL_LSB +: 7] = CALC_LEVEL;
                    next_meas[PRELIM_LSB +: 6] = prelim;
                    next_meas[TEST_LINE_BIT] = test_flag;
                    next_meas[CODE_FOUND_BIT] = code_seen;
                    next_black = ZERO_WORD;
                    next_black[BLACK_LSB +: 7] = BLACK_LEVEL;
                    next_black[EXACT_LSB +: 6] = prelim;
                end
            end
        endcase
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            state <= ST_IDLE;
            shift <= ZERO_WORD;
            bit_cnt <= 3'h0;
            code_seen <= 1'b0;
            run_in <= 1'b0;
            meas <= ZERO_WORD;
            black <= ZERO_WORD;
            DATA_WR <= 1'b0;
            DATA_BYTE <= 8'h00;
            STATUS_WR <= 1'b0;
        end else begin
            state <= next_state;
            shift <= next_shift;
            bit_cnt <= next_bit_cnt;
            code_seen <= next_code_seen;
            run_in <= next_run_in;
            meas <= next_meas;
            black <= next_black;
            DATA_WR <= data_wr_c;
            DATA_BYTE <= data_byte_c;
            STATUS_WR <= status_wr_c;
        end
    end

    assign STATUS_MEAS = meas;
    assign STATUS_BLACK = black;

    ////////////////////////////////////////////////////////////////////////
    // Slicer controls, first slicer only
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            SLICE_LEVEL <= 7'h00;
            GD_STRENGTH <= 4'h0;
            DPLL_TUNE <= 1'b0;
            HPLL_FAST <= 1'b0;
        end else begin
            SLICE_LEVEL <= comp_cfg[LEVEL_SOURCE_BIT]
                ? comp_cfg[SET_LEVEL_LSB +: 7] : CALC_LEVEL;
            GD_STRENGTH <= comp_cfg[GDEN_BIT] ? comp_cfg[GDC_LSB +: 4]
                : 4'h0;
            DPLL_TUNE <= recorder || (state == ST_LINE && !run_in);
            HPLL_FAST <= recorder;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register reads
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            RDATA <= ZERO_WORD;
        end else if (RD) begin
            unique case (ADDR)
                ADDR_RATE: RDATA <= rate_word;
                ADDR_ENABLES: RDATA <= enable_word;
                ADDR_LINE_CFG: RDATA <= line_cfg;
                ADDR_COMP_CFG: RDATA <= comp_cfg;
                ADDR_MEASURE: RDATA <= meas;
                ADDR_BLACK_PHASE: RDATA <= black;
                ADDR_CODES: RDATA <= codes_word;
                ADDR_THIRD_CODE: RDATA <= third_code;
                ADDR_THIRD_MASK: RDATA <= third_mask;
                default: RDATA <= ZERO_WORD;
            endcase
        end else begin
            RDATA <= ZERO_WORD;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    property p_code_found;
        @(posedge CLK) disable iff (RST)
        STATUS_WR |-> meas[CODE_FOUND_BIT] == $past(code_seen);
    endproperty
    a_code_found: assert property (p_code_found)
        else $error("code flag wrong");

    property p_exact;
        @(posedge CLK) disable iff (RST)
        STATUS_WR |-> black[EXACT_LSB +: 6] == meas[PRELIM_LSB +: 6];
    endproperty
    a_exact: assert property (p_exact) else $error("phase count wrong");

    property p_level;
        @(posedge CLK) disable iff (RST)
        ##1 $past(comp_cfg[LEVEL_SOURCE_BIT]) |->
            SLICE_LEVEL == $past(comp_cfg[SET_LEVEL_LSB +: 7]);
    endproperty
    a_level: assert property (p_level) else $error("level wrong");

    property p_gd;
        @(posedge CLK) disable iff (RST)
        ##1 !$past(comp_cfg[GDEN_BIT]) |-> GD_STRENGTH == 4'h0;
    endproperty
    a_gd: assert property (p_gd) else $error("delay comp leaked");

    // Line config is unset after reset, so each mode is checked on its own
    property p_fast;
        @(posedge CLK) disable iff (RST)
        ##1 $past(recorder) |-> HPLL_FAST && DPLL_TUNE;
    endproperty
    a_fast: assert property (p_fast) else $error("pll mode wrong");

    property p_slow;
        @(posedge CLK) disable iff (RST)
        ##1 !$past(recorder) |-> !HPLL_FAST;
    endproperty
    a_slow: assert property (p_slow) else $error("pll mode wrong");

    property p_meas_level;
        @(posedge CLK) disable iff (RST)
        STATUS_WR |-> meas[MEAS_LEVEL_LSB +: 7] == $past(CALC_LEVEL);
    endproperty
    a_meas_level: assert property (p_meas_level)
        else $error("level report wrong");

    property p_black;
        @(posedge CLK) disable iff (RST)
        STATUS_WR |-> black[BLACK_LSB +: 7] == $past(BLACK_LEVEL);
    endproperty
    a_black: assert property (p_black) else $error("black wrong");

    property p_test;
        @(posedge CLK) disable iff (RST)
        STATUS_WR && meas[PRELIM_LSB +: 6] > PHASE_TEST_LIMIT
            |-> meas[TEST_LINE_BIT];
    endproperty
    a_test: assert property (p_test) else $error("test flag wrong");

    property p_nodata;
        @(posedge CLK) disable iff (RST)
        DATA_WR |-> $past(code_seen);
    endproperty
    a_nodata: assert property (p_nodata) else $error("data w/o code");
endmodule : vbs_slicer

// ---- test/test_vbs_slicer.sv ----
`timescale 1ns/1ps
module test_vbs_slicer;
    import vbs_pkg::*;
    logic CLK = 1'b0, RST = 1'b1, WR = 1'b0, RD = 1'b0;
    logic [3:0] ADDR = 4'h0;
    logic [15:0] WDATA = 16'h0000, RDATA, rv, meas, blk;
    logic LINE_START, LINE_END, RUN_IN_DONE, DATA_BIT, BIT_VALID, PHASE_DEV;
    logic ATTEN_DETECT, INSERT_TEST, DPLL_TUNE, HPLL_FAST, DATA_WR, STATUS_WR;
    logic [6:0] CALC_LEVEL, BLACK_LEVEL, SLICE_LEVEL;
    logic [3:0] GD_STRENGTH;
    logic [7:0] DATA_BYTE, first_byte;
    logic [15:0] STATUS_MEAS, STATUS_BLACK;
    int err_count = 0, n_tests = 0, cyc = 0, nwr = 0, nst = 0;
    always #2.5 CLK = ~CLK;
    vbs_slicer uut (.CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA),
        .WR(WR), .RD(RD), .RDATA(RDATA), .LINE_START(LINE_START),
        .LINE_END(LINE_END), .RUN_IN_DONE(RUN_IN_DONE), .DATA_BIT(DATA_BIT),
        .BIT_VALID(BIT_VALID), .PHASE_DEV(PHASE_DEV),
        .CALC_LEVEL(CALC_LEVEL), .BLACK_LEVEL(BLACK_LEVEL),
        .ATTEN_DETECT(ATTEN_DETECT), .INSERT_TEST(INSERT_TEST),
        .SLICE_LEVEL(SLICE_LEVEL), .GD_STRENGTH(GD_STRENGTH),
        .DPLL_TUNE(DPLL_TUNE), .HPLL_FAST(HPLL_FAST), .DATA_WR(DATA_WR),
        .DATA_BYTE(DATA_BYTE), .STATUS_WR(STATUS_WR),
        .STATUS_MEAS(STATUS_MEAS), .STATUS_BLACK(STATUS_BLACK));
    vbs_video_model vid (.clk(CLK), .line_start(LINE_START),
        .line_end(LINE_END), .run_in_done(RUN_IN_DONE), .data_bit(DATA_BIT),
        .bit_valid(BIT_VALID), .phase_dev(PHASE_DEV),
        .calc_level(CALC_LEVEL), .black_level(BLACK_LEVEL),
        .atten_detect(ATTEN_DETECT), .insert_test(INSERT_TEST));
    ////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : end_of_test
    task automatic chk(input string nm, input logic [15:0] s, e);
        n_tests++;
        if (s !== e) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    // Outputs are settled by the falling edge
    always @(negedge CLK) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            end_of_test();
        end
        if (DATA_WR === 1'b1) begin
            if (nwr == 0) first_byte = DATA_BYTE;
            nwr++;
        end
        if (STATUS_WR === 1'b1) begin
            meas = STATUS_MEAS;
            blk = STATUS_BLACK;
            nst++;
        end
    end
    ////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge CLK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CLK);
        WR <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge CLK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CLK);
        RD <= 1'b0;
        #1 d = RDATA;
    endtask : rd
    task automatic t_regs();
        rd(ADDR_RATE, rv);
        chk("rate_reset", rv, 16'hXXXX);
        wr(ADDR_RATE, 16'hD51F);
        rd(ADDR_RATE, rv);
        chk("rate", rv, 16'hD51F);
        rd(4'hF, rv);
        chk("unmapped", rv, ZERO_WORD);
        wr(ADDR_ENABLES, 16'h0C35);
        rd(ADDR_ENABLES, rv);
        chk("enables", rv, 16'h0C35);
    endtask : t_regs
    task automatic t_line(input logic [1:0] sel, input logic [31:0] w,
                          input int n, input int nd, input logic [6:0] cl,
                          input logic [6:0] bl, input logic at, it, fd, cb,
                          input logic [7:0] eb);
        logic [15:0] em, eblk;
        em = {at, cl, nd[5:0], it | (nd > 31), fd};
        eblk = {3'h0, bl, nd[5:0]};
        wr(ADDR_LINE_CFG, {12'h000, sel, 2'h0});
        nwr = 0;
        nst = 0;
        vid.play(w, n, nd, cl, bl, at, it);
        chk("meas", meas, em);
        chk("black", blk, eblk);
        chk("status_writes", 16'(nst), 16'h0001);
        if (cb) chk("byte", {8'h00, first_byte}, {8'h00, eb});
        if (!fd) chk("no_data", 16'(nwr), ZERO_WORD);
        wr(ADDR_MEASURE, 16'hFFFF);
        rd(ADDR_MEASURE, rv);
        chk("meas_ro", rv, em);
        rd(ADDR_BLACK_PHASE, rv);
        chk("black_ro", rv, eblk);
    endtask : t_line
    task automatic t_level(input logic [6:0] cl);
        wr(ADDR_COMP_CFG, 16'h1AD5);
        repeat (2) @(posedge CLK);
        #1 chk("ext_level", {9'h000, SLICE_LEVEL}, 16'h0055);
        chk("gd_on", {12'h000, GD_STRENGTH}, 16'h000A);
        rd(ADDR_COMP_CFG, rv);
        chk("comp_cfg", rv, 16'h1AD5);
        wr(ADDR_COMP_CFG, 16'h0A55);
        repeat (2) @(posedge CLK);
        #1 chk("int_level", {9'h000, SLICE_LEVEL}, {9'h000, cl});
        chk("gd_off", {12'h000, GD_STRENGTH}, ZERO_WORD);
    endtask : t_level
    task automatic t_rec(input logic r);
        wr(ADDR_LINE_CFG, {14'h0000, r, 1'b0});
        repeat (2) @(posedge CLK);
        #1 chk("hpll_fast", {15'h0000, HPLL_FAST}, {15'h0000, r});
        chk("dpll_tune", {15'h0000, DPLL_TUNE}, {15'h0000, r});
    endtask : t_rec
    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge CLK);
        RST <= 1'b0;
        t_regs();
        wr(ADDR_CODES, 16'h3CE4);
        wr(ADDR_THIRD_CODE, 16'hA5C3);
        wr(ADDR_THIRD_MASK, 16'hFFFF);
        t_line(CODE_SEL_FIRST, 32'hE45A, 16, 31, 7'h2A, 7'h11, 1, 0, 1, 1,
               8'h5A);
        t_line(CODE_SEL_SECOND, 32'h3C96, 16, 32, 7'h33, 7'h05, 0, 0, 1, 1,
               8'h96);
        t_line(CODE_SEL_THIRD, 32'hA5C369, 24, 0, 7'h4C, 7'h7F, 1, 1, 1, 1,
               8'h69);
        // External level in use; the report must stay internal
        wr(ADDR_COMP_CFG, 16'h1AD5);
        t_line(CODE_SEL_NONE, 32'hC381, 16, 3, 7'h19, 7'h22, 0, 0, 1, 1,
               8'hC3);
        t_line(CODE_SEL_FIRST, 32'h5A5A, 16, 5, 7'h61, 7'h0C, 0, 0, 0, 0,
               8'h00);
        t_level(7'h61);
        t_rec(1'b1);
        t_rec(1'b0);
        end_of_test();
    end
endmodule : test_vbs_slicer

// ---- test/vbs_video_model.sv ----
`timescale 1ns/1ps
module vbs_video_model (
    input wire logic clk, // Clock
    output logic line_start, // Line begins
    output logic line_end, // Line ends
    output logic run_in_done, // Run-in finished
    output logic data_bit, // Sliced bit
    output logic bit_valid, // Bit strobe
    output logic phase_dev, // Phase deviation
    output logic [6:0] calc_level, // Internal level
    output logic [6:0] black_level, // Black level
    output logic atten_detect, // Attenuation seen
    output logic insert_test // Test line seen
);
    initial begin
        {line_start, line_end, run_in_done, data_bit, bit_valid} = 5'h00;
        {phase_dev, atten_detect, insert_test} = 3'h0;
        calc_level = 7'h00;
        black_level = 7'h00;
    end
    ////////////////////////////////////////////////////////////////////
    // Plays one line: run-in, bits MSB first, deviations, line end
    task automatic play(input logic [31:0] w, input int n, input int ndev,
                        input logic [6:0] cl, input logic [6:0] bl,
                        input logic at, input logic it);
        @(posedge clk);
        line_start <= 1'b1;
        calc_level <= cl;
        black_level <= bl;
        atten_detect <= at;
        insert_test <= it;
        @(posedge clk);
        line_start <= 1'b0;
        repeat (3) @(posedge clk);
        run_in_done <= 1'b1;
        @(posedge clk);
        run_in_done <= 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            @(posedge clk);
            data_bit <= w[i];
            bit_valid <= 1'b1;
            @(posedge clk);
            bit_valid <= 1'b0;
            // Idle data line does not keep its last value
            data_bit <= ~w[i];
        end
        for (int k = 0; k < ndev; k++) begin
            @(posedge clk);
            phase_dev <= 1'b1;
            @(posedge clk);
            phase_dev <= 1'b0;
        end
        @(posedge clk);
        line_end <= 1'b1;
        @(posedge clk);
        line_end <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : play
endmodule : vbs_video_model
